// *** lsa_pkg.sv ***
// Shared constants, bus layouts and helpers for the load/store lane aligner.
// Assumes a 32-bit big-endian word bus and a 32-bit Avalon-MM register port.
package lsa_pkg;
  // ----------------------------------------
  // Access lengths and lane constants
  // ----------------------------------------
  localparam logic [2:0] OPT_WORD = 3'h0;
  localparam logic [2:0] OPT_BYTE = 3'h1;
  localparam logic [2:0] OPT_HALF = 3'h2;
  localparam logic [1:0] BP_SET_VAL = 2'h3;
  localparam logic [1:0] LOW_ZERO = 2'h0;
  localparam logic [1:0] POS_LAST = 2'h3;
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;
  localparam logic [3:0] BE_MSB = 4'h8;
  localparam logic [3:0] BE_HI_HALF = 4'hC;
  localparam logic [3:0] BE_LO_HALF = 4'h3;
  localparam logic [3:0] BE_ALL = 4'hF;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_BPTR = 5'h04;
  localparam logic [4:0] REG_STAT = 5'h08;
  localparam logic [4:0] REG_CLR = 5'h0C;
  localparam logic [4:0] REG_IEN = 5'h10;
  localparam int EV_TRAP = 0;
  localparam int EV_LOAD = 1;
  localparam int NUM_EV = 2;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic store;
    logic [31:0] addr;
    logic [2:0] access_length_option;
    logic sign;
    logic [31:0] src;
    logic imem;
    logic use_bp;
  } lsa_req_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } lsa_mem_t;
  // Misalignment only exists for word and half-word lengths
  function automatic logic lsa_misaligned(input logic [2:0] access_length_option, input logic [1:0] a);
    lsa_misaligned = ((access_length_option == OPT_WORD) && (a != LOW_ZERO)) ||
                     ((access_length_option == OPT_HALF) && (a == POS_LAST));
  endfunction
endpackage

// *** lsa_load_align.sv ***
// Load-side lane extractor: picks a byte or half-word and extends it.
// Assumes the word is already captured; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module lsa_load_align
  import lsa_pkg::*;
(
  input wire logic [31:0] word,
  input wire logic [1:0] pos,
  input wire logic [2:0] access_length_option,
  input wire logic sign,
  output logic [31:0] result
);
  wire logic [7:0] byte_sel;
  wire logic [15:0] half_sel;
  wire logic [1:0] lane;
  assign lane = POS_LAST - pos;
  assign byte_sel = word[BYTE_W*lane +: BYTE_W];
  // Low position bit is ignored, forcing half-word boundaries
  assign half_sel = pos[1] ? word[HALF_W-1:0] : word[2*HALF_W-1:HALF_W];
  always_comb begin
    case (access_length_option)
      OPT_BYTE: result = sign ? {{24{byte_sel[7]}}, byte_sel} : {24'h000000, byte_sel};
      OPT_HALF: result = sign ? {{16{half_sel[15]}}, half_sel} : {16'h0000, half_sel};
      default: result = word;
    endcase
  end
endmodule
`default_nettype wire

// *** lsa_store_lanes.sv ***
// Store-side lane generator: replicated data and lane write enables.
// Assumes position already chosen; the sign flag never reaches here.
`timescale 1ns/1ps
`default_nettype none
module lsa_store_lanes
  import lsa_pkg::*;
(
  input wire logic [31:0] src,
  input wire logic [1:0] pos,
  input wire logic [2:0] access_length_option,
  output logic [31:0] wdata,
  output logic [3:0] be
);
  always_comb begin
    case (access_length_option)
      OPT_BYTE: begin
        wdata = {4{src[BYTE_W-1:0]}};
        be = BE_MSB >> pos;
      end
      OPT_HALF: begin
        wdata = {2{src[HALF_W-1:0]}};
        be = pos[1] ? BE_LO_HALF : BE_HI_HALF;
      end
      default: begin
        wdata = src;
        be = BE_ALL;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** lsa_top.sv ***
// Load/store lane aligner with Avalon-MM control registers and interrupt.
// Assumes memory answers loads with MEM_RVALID/MEM_RDATA from outside this clock.
//
// Behaviour
// - Byte lane from two low address bits
// - Big-endian: 00 top byte, 11 bottom
// - Half-word uses bit one only
// - Position from byte pointer or address
// - Load extracts item right-justified
// - Sign flag clear: zero-fill upper bits
// - Sign flag set: copy item sign bit
// - Store replicates low item across word
// - Store enables only selected lanes
// - Sign flag leaves store lanes alone
// - Sign flag sets byte pointer to 11
// - Trap checking only with enable set
// - Word or half misalignment traps
// - Instruction address low bits always 00
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lsa_top
  import lsa_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PIPE_REQ_VALID,
  input wire lsa_pkg::lsa_req_t PIPE_REQ,
  output logic PIPE_READY,
  output logic PIPE_LOAD_DONE,
  output logic [31:0] PIPE_LOAD_DATA,
  output logic PIPE_TRAP,
  input wire logic [29:0] PIPE_PC,
  output logic [31:0] IF_ADDR,
  output var lsa_pkg::lsa_mem_t MEM,
  input wire logic MEM_RVALID,
  input wire logic [31:0] MEM_RDATA,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic IRQ
);
  typedef enum logic {ST_IDLE, ST_LOAD} lsa_state_t;

  // ----------------------------------------
  // State
  // ----------------------------------------
  lsa_state_t state_q;
  logic ready_q, done_q, trap_q, ten_q, irq_q, wait_q;
  logic [31:0] ldata_q, if_q, rdata_q;
  lsa_mem_t mem_q;
  logic [1:0] bp_q, ld_pos_q;
  logic [2:0] ld_opt_q;
  logic ld_sign_q;
  logic [NUM_EV-1:0] stat_q, ien_q;
  logic rv_s1_q, rv_s2_q, rv_s3_q;
  logic [31:0] rd_s1_q, rd_s2_q;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  wire logic acc, trap_hit, st_go, ld_go, bp_set, ld_fin;
  wire logic [1:0] pos;
  wire logic [31:0] st_wdata, ld_result;
  wire logic [3:0] st_be;
  assign acc = PIPE_REQ_VALID && ready_q;
  assign pos = PIPE_REQ.use_bp ? bp_q : PIPE_REQ.addr[1:0];
  // Trap check reads the address bits, never the byte pointer
  assign trap_hit = acc && ten_q && PIPE_REQ.imem &&
                    lsa_misaligned(PIPE_REQ.access_length_option, PIPE_REQ.addr[1:0]);
  assign st_go = acc && !trap_hit && PIPE_REQ.store;
  assign ld_go = acc && !trap_hit && !PIPE_REQ.store;
  assign bp_set = (st_go || ld_go) && PIPE_REQ.sign;
  // Only a fresh rise of the synchronised valid ends a load; a memory still
  // holding valid from the last load must not finish the next one early
  assign ld_fin = (state_q == ST_LOAD) && rv_s2_q && !rv_s3_q;

  // Sign flag deliberately not routed into the store path
  lsa_store_lanes u_store (
    .src(PIPE_REQ.src),
    .pos(pos),
    .access_length_option(PIPE_REQ.access_length_option),
    .wdata(st_wdata),
    .be(st_be)
  );

  lsa_load_align u_load (
    .word(rd_s2_q),
    .pos(ld_pos_q),
    .access_length_option(ld_opt_q),
    .sign(ld_sign_q),
    .result(ld_result)
  );

  // ----------------------------------------
  // Register bus decode
  // ----------------------------------------
  wire logic bus_wr, bus_rd, wr_ctrl, wr_bptr, wr_clr, wr_ien;
  wire logic [NUM_EV-1:0] ev, clr_mask, stat_d;
  wire logic [1:0] bp_d;
  wire logic [31:0] rd_mux;
  // Writes take effect only on the edge where waitrequest is seen low
  assign bus_wr = AVS_WRITE && !wait_q && AVS_BYTEENABLE[0];
  assign bus_rd = AVS_READ && wait_q;
  assign wr_ctrl = bus_wr && (AVS_ADDRESS == REG_CTRL);
  assign wr_bptr = bus_wr && (AVS_ADDRESS == REG_BPTR);
  assign wr_clr = bus_wr && (AVS_ADDRESS == REG_CLR);
  assign wr_ien = bus_wr && (AVS_ADDRESS == REG_IEN);
  assign ev = {ld_fin, trap_hit};
  assign clr_mask = wr_clr ? AVS_WRITEDATA[NUM_EV-1:0] : '0;
  // New event wins over a clear in the same cycle
  assign stat_d = (stat_q & ~clr_mask) | ev;
  // Hardware pointer set wins over a software write
  assign bp_d = bp_set ? BP_SET_VAL : (wr_bptr ? AVS_WRITEDATA[1:0] : bp_q);
  assign rd_mux = (AVS_ADDRESS == REG_CTRL) ? {31'h00000000, ten_q} :
                  (AVS_ADDRESS == REG_BPTR) ? {30'h00000000, bp_q} :
                  (AVS_ADDRESS == REG_STAT) ? {30'h00000000, stat_q} :
                  (AVS_ADDRESS == REG_IEN) ? {30'h00000000, ien_q} : 32'h00000000;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    rv_s1_q <= SRST ? 1'b0 : MEM_RVALID;
    rv_s2_q <= SRST ? 1'b0 : rv_s1_q;
    // Edge stage idles low like the pin, so reset brings no false edge
    rv_s3_q <= SRST ? 1'b0 : rv_s2_q;
    rd_s1_q <= MEM_RDATA;
    rd_s2_q <= rd_s1_q;
  end

  // ----------------------------------------
  // Access sequencing
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (ld_go) begin
            state_q <= ST_LOAD;
            ready_q <= 1'b0;
          end
        end
        ST_LOAD: begin
          if (ld_fin) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      mem_q <= '0;
      trap_q <= 1'b0;
      done_q <= 1'b0;
      ldata_q <= 32'h00000000;
      ld_pos_q <= 2'h0;
      ld_opt_q <= OPT_WORD;
      ld_sign_q <= 1'b0;
    end else begin
      mem_q.rd <= ld_go;
      mem_q.wr <= st_go;
      trap_q <= trap_hit;
      done_q <= ld_fin;
      if (st_go || ld_go) begin
        // Word address only; lanes carry the byte position
        mem_q.addr <= {PIPE_REQ.addr[31:2], LOW_ZERO};
        mem_q.be <= ld_go ? BE_ALL : st_be;
        mem_q.wdata <= st_wdata;
      end
      if (ld_go) begin
        ld_pos_q <= pos;
        ld_opt_q <= PIPE_REQ.access_length_option;
        ld_sign_q <= PIPE_REQ.sign;
      end
      if (ld_fin) begin
        ldata_q <= ld_result;
      end
    end
  end

  // Instruction fetch address; jump targets arrive already word-truncated
  always_ff @(posedge CLK) begin
    if_q <= SRST ? 32'h00000000 : {PIPE_PC, LOW_ZERO};
  end

  // ----------------------------------------
  // Registers and interrupt
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ten_q <= 1'b0;
      bp_q <= 2'h0;
      stat_q <= '0;
      ien_q <= '0;
      irq_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      // One-cycle answer: waitrequest drops for a single edge per request
      wait_q <= !((AVS_READ || AVS_WRITE) && wait_q);
      if (bus_rd) begin
        rdata_q <= rd_mux;
      end
      if (wr_ctrl) begin
        ten_q <= AVS_WRITEDATA[0];
      end
      if (wr_ien) begin
        ien_q <= AVS_WRITEDATA[NUM_EV-1:0];
      end
      bp_q <= bp_d;
      stat_q <= stat_d;
      irq_q <= |(stat_q & ien_q);
    end
  end

  assign PIPE_READY = ready_q;
  assign PIPE_LOAD_DONE = done_q;
  assign PIPE_LOAD_DATA = ldata_q;
  assign PIPE_TRAP = trap_q;
  assign IF_ADDR = if_q;
  assign MEM = mem_q;
  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign IRQ = irq_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // Pipeline side: pointer, trap gate and bus access
  bp_set_a: assert property (bp_set |=> bp_q == BP_SET_VAL)
    else $error("Byte pointer not set after signed access");
  bp_pos_a: assert property (ld_go && PIPE_REQ.use_bp |=> ld_pos_q == $past(bp_q))
    else $error("Pointer-based load took the wrong position");
  trap_gate_a: assert property (acc && !ten_q |=> !trap_q)
    else $error("Trap raised while checking disabled");
  word_trap_a: assert property (
    acc && ten_q && PIPE_REQ.imem && PIPE_REQ.access_length_option == OPT_WORD &&
    PIPE_REQ.addr[1:0] != LOW_ZERO |=> trap_q)
    else $error("Misaligned word access did not trap");
  half_trap_a: assert property (
    acc && ten_q && PIPE_REQ.imem && PIPE_REQ.access_length_option == OPT_HALF &&
    PIPE_REQ.addr[1:0] == POS_LAST |=> trap_q)
    else $error("Misaligned half-word access did not trap");
  trap_quiet_a: assert property (trap_q |-> !mem_q.rd && !mem_q.wr && !done_q)
    else $error("Trapped access reached the bus");
  no_wb_a: assert property (trap_hit |=> $stable(ldata_q))
    else $error("Trapped access changed load data");
  fetch_align_a: assert property (##1 IF_ADDR == {$past(PIPE_PC), LOW_ZERO})
    else $error("Instruction address not word aligned");
  word_addr_a: assert property ((st_go || ld_go) |=> mem_q.addr[1:0] == LOW_ZERO)
    else $error("Bus address carries a byte offset");
  store_lanes_a: assert property (
    st_go && PIPE_REQ.access_length_option == OPT_BYTE |=> mem_q.wr && $countones(mem_q.be) == 1)
    else $error("Byte store enabled wrong lane count");
  store_repl_a: assert property (
    st_go && PIPE_REQ.access_length_option == OPT_HALF |=> mem_q.wdata[31:16] == mem_q.wdata[15:0])
    else $error("Half-word store data not replicated");
  // Load side: a load holds the pipeline until its single completion
  ready_drop_a: assert property (ld_go |=> !PIPE_READY && state_q == ST_LOAD)
    else $error("Pipeline ready during an outstanding load");
  done_pulse_a: assert property (done_q |=> !done_q)
    else $error("Load completion repeated without new data");
  zero_ext_a: assert property (
    ld_fin && !ld_sign_q && ld_opt_q == OPT_BYTE |=>
    done_q && PIPE_LOAD_DATA[31:8] == 24'h000000)
    else $error("Unsigned byte load not zero extended");
  sign_ext_a: assert property (
    ld_fin && ld_sign_q && ld_opt_q == OPT_HALF |=>
    PIPE_LOAD_DATA[31:16] == {16{PIPE_LOAD_DATA[15]}})
    else $error("Signed half-word load not sign extended");
  half_lane_a: assert property (
    ld_fin && ld_opt_q == OPT_HALF && !ld_pos_q[1] |-> ld_result[15:0] == rd_s2_q[31:16])
    else $error("Half-word position zero is not the upper half");
  lane_order_a: assert property (
    ld_fin && ld_opt_q == OPT_BYTE && ld_pos_q == LOW_ZERO |=>
    PIPE_LOAD_DATA[7:0] == $past(rd_s2_q[31:24]))
    else $error("Byte lane zero is not the top byte");
  irq_level_a: assert property ((|(stat_q & ien_q)) |=> IRQ)
    else $error("Interrupt low with an enabled event pending");

  // Main scenarios the bench is expected to reach
  store_seen_c: cover property (st_go ##1 mem_q.wr);
  load_seen_c: cover property (ld_go ##[1:20] done_q);
  trap_seen_c: cover property (trap_hit ##1 trap_q);
  bus_wr_c: cover property (wr_bptr);
  signed_store_c: cover property (st_go && PIPE_REQ.sign);
endmodule
`default_nettype wire

// *** lsa_mem_model.sv ***
// Memory model on the word bus: stores by lane, answers loads late.
// Assumes MEM pulses from the aligner; DELAY sets extra answer cycles.
`timescale 1ns/1ps
`default_nettype none
module lsa_mem_model
  import lsa_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire lsa_pkg::lsa_mem_t MEM,
  input wire logic [3:0] DELAY,
  output logic MEM_RVALID,
  output logic [31:0] MEM_RDATA
);
  // ----------------------------------------
  // Storage and answer timing
  // ----------------------------------------
  logic [31:0] mem_q [16];
  logic [3:0] wait_q;
  logic [3:0] idx_q;
  logic [1:0] hold_q;
  logic busy_q;
  // Word index only: the low address bits never reach the array
  always_ff @(posedge CLK) begin
    if (SRST) begin
      busy_q <= 1'b0;
      hold_q <= 2'h0;
      MEM_RVALID <= 1'b0;
      MEM_RDATA <= 32'h0;
    end else begin
      if (MEM.wr)
        for (int i = 0; i < 4; i++)
          if (MEM.be[i]) mem_q[MEM.addr[5:2]][8*i+:8] <= MEM.wdata[8*i+:8];
      if (MEM.rd) begin
        busy_q <= 1'b1;
        wait_q <= DELAY;
        idx_q <= MEM.addr[5:2];
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        hold_q <= 2'h3;
        MEM_RVALID <= 1'b1;
        MEM_RDATA <= mem_q[idx_q];
      end else begin
        // Valid held 3 cycles, then data scrambles so stale values never pass
        if (hold_q != 2'h0) hold_q <= hold_q - 2'h1;
        MEM_RVALID <= (hold_q > 2'h1);
        if (hold_q <= 2'h1) MEM_RDATA <= ~MEM_RDATA;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb_load_store_lane_aligner.sv ***
// Testbench for the lane aligner: pipeline accesses and register port.
// Assumes the memory model answers loads on the asynchronous return pins.
`timescale 1ns/1ps
`default_nettype none
module tb_load_store_lane_aligner;
  import lsa_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic CLK = 0, SRST = 1, PIPE_REQ_VALID = 0, PIPE_READY, PIPE_LOAD_DONE, PIPE_TRAP;
  logic MEM_RVALID, AVS_READ = 0, AVS_WRITE = 0, AVS_WAITREQUEST, IRQ, trap;
  logic [29:0] PIPE_PC = '0;
  logic [31:0] PIPE_LOAD_DATA, IF_ADDR, MEM_RDATA, AVS_READDATA, AVS_WRITEDATA = '0;
  logic [31:0] ld, prev, q;
  logic [4:0] AVS_ADDRESS = '0;
  logic [3:0] AVS_BYTEENABLE = '0, delay = '0;
  logic [5:0] tc [6] = '{6'h03, 6'h05, 6'h07, 6'h17, 6'h12, 6'h0E};
  lsa_req_t PIPE_REQ = '0;
  lsa_mem_t MEM, snap;
  int n_mismatch = 0, checked = 0, cycles = 0;
  localparam logic [31:0] W = 32'h81F27F04;
  localparam logic [31:0] S = 32'h1234A5C3;
  lsa_top u_dut (.CLK(CLK), .SRST(SRST), .PIPE_REQ_VALID(PIPE_REQ_VALID),
    .PIPE_REQ(PIPE_REQ), .PIPE_READY(PIPE_READY), .PIPE_LOAD_DONE(PIPE_LOAD_DONE),
    .PIPE_LOAD_DATA(PIPE_LOAD_DATA), .PIPE_TRAP(PIPE_TRAP), .PIPE_PC(PIPE_PC),
    .IF_ADDR(IF_ADDR), .MEM(MEM), .MEM_RVALID(MEM_RVALID), .MEM_RDATA(MEM_RDATA),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ));
  lsa_mem_model u_mem (.CLK(CLK), .SRST(SRST), .MEM(MEM), .DELAY(delay),
    .MEM_RVALID(MEM_RVALID), .MEM_RDATA(MEM_RDATA));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Extra edge at the end keeps back-to-back calls from double driving
  task automatic avs(input logic w, input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] b);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= b;
    @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic acc(input logic st, input logic [31:0] a, input logic [2:0] o,
      input logic sg, input logic ub, input logic [31:0] s);
    PIPE_REQ <= '{st, a, o, sg, s, 1'b1, ub};
    PIPE_REQ_VALID <= 1'b1;
    @(posedge CLK);
    PIPE_REQ_VALID <= 1'b0;
    do @(posedge CLK); while (!(MEM.wr | MEM.rd | PIPE_TRAP));
    snap = MEM;
    trap = PIPE_TRAP;
    if (MEM.rd) begin
      do @(posedge CLK); while (PIPE_LOAD_DONE !== 1'b1);
      ld = PIPE_LOAD_DATA;
    end
  endtask
  function automatic logic [31:0] xld(input logic [2:0] o, input logic [1:0] a,
      input logic sg);
    logic [7:0] b;
    logic [15:0] h;
    b = W[31 - 8 * int'(a) -: 8];
    h = a[1] ? W[15:0] : W[31:16];
    if (o == OPT_BYTE) xld = {{24{sg & b[7]}}, b};
    else if (o == OPT_HALF) xld = {{16{sg & h[15]}}, h};
    else xld = W;
  endfunction
  // ----------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------
  initial forever #50 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    chk(PIPE_READY, 1'b1);
    acc(1'b1, 32'h10, OPT_WORD, 1'b0, 1'b0, W);
    chk(snap.be, 4'hF);
    for (int i = 0; i < 16; i++) begin
      delay <= i[0] ? 4'h6 : 4'h0;
      acc(1'b0, 32'h10 + i[1:0], i[2] ? OPT_HALF : OPT_BYTE, i[3], 1'b0, 32'h0);
      chk(ld, xld(i[2] ? OPT_HALF : OPT_BYTE, i[1:0], i[3]));
      acc(1'b1, 32'h20 + i[1:0], i[2] ? OPT_HALF : OPT_BYTE, i[3], 1'b0, S);
      chk(snap.wdata, i[2] ? {2{S[15:0]}} : {4{S[7:0]}});
      chk(snap.be, i[2] ? (i[1] ? 4'h3 : 4'hC) : 4'h8 >> i[1:0]);
      chk(snap.addr, 32'h20);
    end
    avs(1'b0, 5'h04, 32'h0, 4'hF);
    chk(q[1:0], 2'h3);
    avs(1'b1, 5'h04, 32'h1, 4'hF);
    avs(1'b1, 5'h04, 32'h2, 4'h0);
    acc(1'b0, 32'h10, OPT_BYTE, 1'b0, 1'b1, 32'h0);
    chk(ld, 32'hF2);
    acc(1'b0, 32'h13, OPT_WORD, 1'b0, 1'b0, 32'h0);
    chk(trap, 1'b0);
    chk(ld, W);
    avs(1'b1, 5'h00, 32'h1, 4'hF);
    for (int i = 0; i < 6; i++) begin
      prev = PIPE_LOAD_DATA;
      acc(1'b0, 32'h10 + tc[i][2:1], tc[i][5:3], 1'b0, 1'b0, 32'h0);
      chk(trap, tc[i][0]);
      if (tc[i][0]) begin
        chk({snap.rd, snap.wr}, 32'h0);
        chk(PIPE_LOAD_DATA, prev);
      end else begin
        chk(ld, xld(tc[i][5:3], tc[i][2:1], 1'b0));
      end
    end
    avs(1'b0, 5'h08, 32'h0, 4'hF);
    chk(q, 32'h3);
    chk(IRQ, 1'b0);
    avs(1'b1, 5'h10, 32'h1, 4'hF);
    repeat (3) @(posedge CLK);
    chk(IRQ, 1'b1);
    avs(1'b1, 5'h0C, 32'h1, 4'hF);
    avs(1'b0, 5'h08, 32'h0, 4'hF);
    chk(q, 32'h2);
    repeat (3) @(posedge CLK);
    chk(IRQ, 1'b0);
    avs(1'b0, 5'h14, 32'h0, 4'hF);
    chk(q, 32'h0);
    PIPE_PC <= 30'h2AAAAAAB;
    repeat (3) @(posedge CLK);
    chk(IF_ADDR, {PIPE_PC, 2'b00});
    complete_run();
  end
endmodule
`default_nettype wire
